// [hw/gpmp_defs.vh]
`ifndef GPMP_DEFS_VH
`define GPMP_DEFS_VH

// Register word indices; byte address is four times the index.
`define GPMP_IDX_VALUE_LO 10'h000
`define GPMP_IDX_VALUE_HI 10'h0FF
`define GPMP_IDX_DIR 10'h100
`define GPMP_IDX_SENSE 10'h101
`define GPMP_IDX_BOTH 10'h102
`define GPMP_IDX_POL 10'h103
`define GPMP_IDX_MASK 10'h104
`define GPMP_IDX_RAW 10'h105
`define GPMP_IDX_MSTAT 10'h106
`define GPMP_IDX_CLEAR 10'h107
`define GPMP_IDX_ALT 10'h108
`define GPMP_IDX_DR2 10'h140
`define GPMP_IDX_DR4 10'h141
`define GPMP_IDX_DR8 10'h142
`define GPMP_IDX_ODR 10'h143
`define GPMP_IDX_PUR 10'h144
`define GPMP_IDX_PDR 10'h145
`define GPMP_IDX_SLR 10'h146
`define GPMP_IDX_DEN 10'h147
`define GPMP_IDX_LOCK 10'h148
`define GPMP_IDX_COMMIT 10'h149
`define GPMP_IDX_ID_LO 10'h3F4
`define GPMP_IDX_ID_HI 10'h3FF

// Address field positions.
`define GPMP_ADDR_IDX_HI 11
`define GPMP_ADDR_IDX_LO 2
`define GPMP_ADDR_MASK_HI 9
`define GPMP_ADDR_MASK_LO 2

// Reset values.
`define GPMP_RST_ZERO 8'h00
`define GPMP_RST_DR2 8'hFF
`define GPMP_RST_COMMIT 8'hFF
`define GPMP_RST_OE_N 8'hFF

// Unlock key and lock status readback.
`define GPMP_LOCK_KEY 32'h1ACCE551
`define GPMP_LOCK_LOCKED 32'h00000001
`define GPMP_LOCK_OPEN 32'h00000000

`endif

// [hw/gpmp_port.v]
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
// Contract
// - Ordinary pins reset undriven: alternate, digital enable, pulls all off.
// - Debug pins reset with alternate, digital enable and pull-up set.
// - Any reset returns both pin groups to their defaults.
// - Direction 0: pin is input, value bit captures the pin.
// - Direction 1: pin is output, stored value drives the pad.
// - Address bits 9..2 mask the eight value bits.
// - Pin value register spans 256 word locations.
// - Masked write updates only bits whose address bit is one.
// - Masked read returns zero for bits whose address bit is zero.
// - All pin interrupts combine into one port interrupt output.
// - Sense, both-edges and polarity select each pin trigger.
// - Sense 1 level; both 1 two edges; polarity 1 high or rising.
// - Mask bit 1 lets a pin's interrupt reach the output.
// - Raw status ignores mask; masked status shows passing conditions only.
// - Edge interrupt stays pending until software clears it.
// - Writing 1 to clear register clears that pin; 0 does nothing.
// - Unmasked port B pin four interrupt also pulses converter trigger.
// - Alternate select gives the pin to the peripheral.
// - Protected alternate bits change only when unlocked and commit-allowed.
// - Commit allow resets all ones except protected pins, which reset zero.
// - Per-pin drive, open-drain, pulls, slew and digital enable settings.
// - Debug-reset pin returns to debug role at every reset.
// - Fixed read-only identification words.
`include "gpmp_defs.vh"
module gpmp_port #(
  parameter [7:0] PROTECT_MASK = 8'h00,
  parameter [7:0] TRIG_MASK = 8'h00,
  parameter [7:0] ID_BYTE = 8'h5A // Arbitrary identification value.
) (
  // Clock and reset.
  input wire sys_clk,
  input wire rst_n,
  // Register port.
  input wire [11:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Pads.
  input wire [7:0] pad_in,
  output reg [7:0] pad_out,
  output reg [7:0] pad_oe_n,
  output reg [7:0] pad_pull_up,
  output reg [7:0] pad_pull_down,
  output reg [7:0] pad_drive_2ma,
  output reg [7:0] pad_drive_4ma,
  output reg [7:0] pad_drive_8ma,
  output reg [7:0] pad_slew_limit,
  output reg [7:0] pad_digital_en,
  // Peripheral side.
  input wire [7:0] periph_out,
  input wire [7:0] periph_oe,
  output reg [7:0] periph_in,
  // Events.
  output reg port_irq,
  output reg conv_trigger
);

  // Register file; every field but unlocked_r and trig_prev_r is eight bits wide, one bit per pin.
  reg [7:0] pin_direction_bits_r;
  reg [7:0] pin_value_bits_r;
  reg [7:0] irq_sense_select_r;
  reg [7:0] irq_both_edges_select_r;
  reg [7:0] irq_event_polarity_r;
  reg [7:0] irq_mask_bits_r;
  reg [7:0] edge_pend_r;
  reg [7:0] alt_function_select_r;
  reg [7:0] drive_2ma_select_r;
  reg [7:0] drive_4ma_select_r;
  reg [7:0] drive_8ma_select_r;
  reg [7:0] open_drain_select_r;
  reg [7:0] pull_up_select_r;
  reg [7:0] pull_down_select_r;
  reg [7:0] slew_limit_select_r;
  reg [7:0] digital_enable_bits_r;
  reg [7:0] commit_allow_bits_r;
  reg unlocked_r;
  reg [7:0] sync1_r;
  reg [7:0] sync2_r;
  reg [7:0] prev_r;
  reg trig_prev_r;

  wire [9:0] idx = reg_addr[`GPMP_ADDR_IDX_HI:`GPMP_ADDR_IDX_LO];
  wire [7:0] amask = reg_addr[`GPMP_ADDR_MASK_HI:`GPMP_ADDR_MASK_LO];
  wire [7:0] wbyte = reg_wdata[7:0];

  // One write strobe per register index, shared by every write below but the pin value write.
  // Only the index is compared; mask bits inside the value window are decoded apart.
  function wr_hit;
    input [9:0] want;
    begin
      wr_hit = reg_wr && (idx == want);
    end
  endfunction

  // The value window covers indices 0x000 to 0x0FF inclusive.
  wire value_sel = (idx <= `GPMP_IDX_VALUE_HI);

  // Trigger detection per pin from synchronised samples.
  wire [7:0] rise = sync2_r & ~prev_r;
  wire [7:0] fall = ~sync2_r & prev_r;
  reg [7:0] edge_evt;
  reg [7:0] level_act;
  integer i;
  always @* begin
    edge_evt = 8'h00;
    level_act = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      // Both-edges overrides polarity for edge pins.
      if (irq_both_edges_select_r[i]) begin
        edge_evt[i] = rise[i] | fall[i];
      end else if (irq_event_polarity_r[i]) begin
        edge_evt[i] = rise[i];
      end else begin
        edge_evt[i] = fall[i];
      end
      level_act[i] = irq_event_polarity_r[i] ? sync2_r[i] : ~sync2_r[i];
    end
  end

  // Level pins show raw status straight from the pin; edge pins from the latch.
  // Level status is live, so it drops as soon as the pin leaves its active level.
  wire [7:0] raw_status = (irq_sense_select_r & level_act) |
                          (~irq_sense_select_r & edge_pend_r);
  wire [7:0] masked_status = raw_status & irq_mask_bits_r;
  wire [7:0] clr_bits = wr_hit(`GPMP_IDX_CLEAR) ? wbyte : 8'h00;
  // The trigger pin's status, seen through its mask, feeds the converter trigger.
  wire trig_now = |(masked_status & TRIG_MASK);

  // Input synchroniser; the first stage is read only by the second.
  // Two stages cost two cycles of latency but give margin against metastability.
  // The previous sample is kept so that edges are found between successive samples.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= `GPMP_RST_ZERO;
      sync2_r <= `GPMP_RST_ZERO;
      prev_r <= `GPMP_RST_ZERO;
    end else begin
      sync1_r <= pad_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // Edge pending latch; a new edge in the clear cycle wins over the clear.
  // Clearing a level pin does nothing, as level status is never latched.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_pend_r <= `GPMP_RST_ZERO;
    end else begin
      edge_pend_r <= (edge_pend_r & ~clr_bits) | (edge_evt & ~irq_sense_select_r);
    end
  end

  // Pin value: input pins capture the pad, output pins take masked writes.
  // A value write to an input pin is lost, because the capture wins every cycle.
  integer k;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_value_bits_r <= `GPMP_RST_ZERO;
    end else begin
      for (k = 0; k < 8; k = k + 1) begin
        if (!pin_direction_bits_r[k]) begin
          pin_value_bits_r[k] <= sync2_r[k];
        end else if (reg_wr && value_sel && amask[k]) begin
          pin_value_bits_r[k] <= wbyte[k];
        end
      end
    end
  end

  // Configuration registers. Debug pins get their own defaults at every reset.
  // Drive strength comes up at the weakest setting on every pin.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_direction_bits_r <= `GPMP_RST_ZERO;
      irq_sense_select_r <= `GPMP_RST_ZERO;
      irq_both_edges_select_r <= `GPMP_RST_ZERO;
      irq_event_polarity_r <= `GPMP_RST_ZERO;
      irq_mask_bits_r <= `GPMP_RST_ZERO;
      alt_function_select_r <= PROTECT_MASK;
      digital_enable_bits_r <= PROTECT_MASK;
      pull_up_select_r <= PROTECT_MASK;
      pull_down_select_r <= `GPMP_RST_ZERO;
      drive_2ma_select_r <= `GPMP_RST_DR2;
      drive_4ma_select_r <= `GPMP_RST_ZERO;
      drive_8ma_select_r <= `GPMP_RST_ZERO;
      open_drain_select_r <= `GPMP_RST_ZERO;
      slew_limit_select_r <= `GPMP_RST_ZERO;
      commit_allow_bits_r <= `GPMP_RST_COMMIT & ~PROTECT_MASK;
      unlocked_r <= 1'b0;
    end else begin
      if (wr_hit(`GPMP_IDX_DIR)) begin
        pin_direction_bits_r <= wbyte;
      end
      // Changing these with the pin unmasked can raise a spurious event.
      if (wr_hit(`GPMP_IDX_SENSE)) begin
        irq_sense_select_r <= wbyte;
      end
      if (wr_hit(`GPMP_IDX_BOTH)) begin
        irq_both_edges_select_r <= wbyte;
      end
      if (wr_hit(`GPMP_IDX_POL)) begin
        irq_event_polarity_r <= wbyte;
      end
      if (wr_hit(`GPMP_IDX_MASK)) begin
        irq_mask_bits_r <= wbyte;
      end
      // Unprotected bits always write; protected ones need unlock and allow.
      // A refused write leaves protected bits as they were, with no error.
      if (wr_hit(`GPMP_IDX_ALT)) begin
        alt_function_select_r <= (wbyte & ~PROTECT_MASK) |
          ((unlocked_r ? (commit_allow_bits_r & PROTECT_MASK) : 8'h00) & wbyte) |
          (alt_function_select_r & PROTECT_MASK &
           ~(unlocked_r ? commit_allow_bits_r : 8'h00));
      end
      if (wr_hit(`GPMP_IDX_DR2)) begin
        drive_2ma_select_r <= wbyte;
      end
      if (wr_hit(`GPMP_IDX_DR4)) begin
        drive_4ma_select_r <= wbyte;
      end
      if (wr_hit(`GPMP_IDX_DR8)) begin
        drive_8ma_select_r <= wbyte;
      end
      if (wr_hit(`GPMP_IDX_ODR)) begin
        open_drain_select_r <= wbyte;
      end
      if (wr_hit(`GPMP_IDX_PUR)) begin
        pull_up_select_r <= wbyte;
      end
      if (wr_hit(`GPMP_IDX_PDR)) begin
        pull_down_select_r <= wbyte;
      end
      if (wr_hit(`GPMP_IDX_SLR)) begin
        slew_limit_select_r <= wbyte;
      end
      if (wr_hit(`GPMP_IDX_DEN)) begin
        digital_enable_bits_r <= wbyte;
      end
      // Commit allow is writable only on protected pins and only when unlocked.
      // Bits of ordinary pins stay set, so their alternate select always commits.
      if (wr_hit(`GPMP_IDX_COMMIT) && unlocked_r) begin
        commit_allow_bits_r <= (commit_allow_bits_r & ~PROTECT_MASK) |
                               (wbyte & PROTECT_MASK);
      end
      // Any write to the lock: the key opens it, anything else closes it.
      if (wr_hit(`GPMP_IDX_LOCK)) begin
        unlocked_r <= (reg_wdata == `GPMP_LOCK_KEY);
      end
    end
  end

  // Read mux, registered so data stand in the cycle after the strobe.
  // Unmapped indices read zero, so probing software sees no stale data.
  // The lock word reads one while closed and zero while open.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      if (value_sel) begin
        reg_rdata <= {24'h000000, pin_value_bits_r & amask};
      end else if (idx == `GPMP_IDX_DIR) begin
        reg_rdata <= {24'h000000, pin_direction_bits_r};
      end else if (idx == `GPMP_IDX_SENSE) begin
        reg_rdata <= {24'h000000, irq_sense_select_r};
      end else if (idx == `GPMP_IDX_BOTH) begin
        reg_rdata <= {24'h000000, irq_both_edges_select_r};
      end else if (idx == `GPMP_IDX_POL) begin
        reg_rdata <= {24'h000000, irq_event_polarity_r};
      end else if (idx == `GPMP_IDX_MASK) begin
        reg_rdata <= {24'h000000, irq_mask_bits_r};
      end else if (idx == `GPMP_IDX_RAW) begin
        reg_rdata <= {24'h000000, raw_status};
      end else if (idx == `GPMP_IDX_MSTAT) begin
        reg_rdata <= {24'h000000, masked_status};
      end else if (idx == `GPMP_IDX_ALT) begin
        reg_rdata <= {24'h000000, alt_function_select_r};
      end else if (idx == `GPMP_IDX_DR2) begin
        reg_rdata <= {24'h000000, drive_2ma_select_r};
      end else if (idx == `GPMP_IDX_DR4) begin
        reg_rdata <= {24'h000000, drive_4ma_select_r};
      end else if (idx == `GPMP_IDX_DR8) begin
        reg_rdata <= {24'h000000, drive_8ma_select_r};
      end else if (idx == `GPMP_IDX_ODR) begin
        reg_rdata <= {24'h000000, open_drain_select_r};
      end else if (idx == `GPMP_IDX_PUR) begin
        reg_rdata <= {24'h000000, pull_up_select_r};
      end else if (idx == `GPMP_IDX_PDR) begin
        reg_rdata <= {24'h000000, pull_down_select_r};
      end else if (idx == `GPMP_IDX_SLR) begin
        reg_rdata <= {24'h000000, slew_limit_select_r};
      end else if (idx == `GPMP_IDX_DEN) begin
        reg_rdata <= {24'h000000, digital_enable_bits_r};
      end else if (idx == `GPMP_IDX_LOCK) begin
        reg_rdata <= unlocked_r ? `GPMP_LOCK_OPEN : `GPMP_LOCK_LOCKED;
      end else if (idx == `GPMP_IDX_COMMIT) begin
        reg_rdata <= {24'h000000, commit_allow_bits_r};
      end else if (idx >= `GPMP_IDX_ID_LO) begin
        reg_rdata <= {24'h000000, ID_BYTE ^ {6'h00, idx[1:0]}};
      end else begin
        reg_rdata <= 32'h00000000;
      end
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // Pad drive: alternate function hands the pad to the peripheral.
  // Open drain only drives low, so a high value releases the pad.
  reg [7:0] drv_val;
  reg [7:0] drv_en;
  // A loop index of its own keeps this process apart from the trigger decode.
  integer j;
  always @* begin
    drv_val = 8'h00;
    drv_en = 8'h00;
    for (j = 0; j < 8; j = j + 1) begin
      drv_val[j] = alt_function_select_r[j] ? periph_out[j] : pin_value_bits_r[j];
      drv_en[j] = alt_function_select_r[j] ? periph_oe[j] : pin_direction_bits_r[j];
      if (open_drain_select_r[j] && drv_val[j]) begin
        drv_en[j] = 1'b0;
      end
      if (!digital_enable_bits_r[j]) begin
        drv_en[j] = 1'b0;
      end
    end
  end

  // Registered pad and event outputs.
  // Pad controls follow their registers one cycle behind.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_out <= `GPMP_RST_ZERO;
      pad_oe_n <= `GPMP_RST_OE_N;
      pad_pull_up <= `GPMP_RST_ZERO;
      pad_pull_down <= `GPMP_RST_ZERO;
      pad_drive_2ma <= `GPMP_RST_ZERO;
      pad_drive_4ma <= `GPMP_RST_ZERO;
      pad_drive_8ma <= `GPMP_RST_ZERO;
      pad_slew_limit <= `GPMP_RST_ZERO;
      pad_digital_en <= `GPMP_RST_ZERO;
      periph_in <= `GPMP_RST_ZERO;
      port_irq <= 1'b0;
      conv_trigger <= 1'b0;
      trig_prev_r <= 1'b0;
    end else begin
      pad_out <= drv_val;
      pad_oe_n <= ~drv_en;
      pad_pull_up <= pull_up_select_r;
      pad_pull_down <= pull_down_select_r;
      pad_drive_2ma <= drive_2ma_select_r;
      pad_drive_4ma <= drive_4ma_select_r;
      pad_drive_8ma <= drive_8ma_select_r;
      pad_slew_limit <= slew_limit_select_r;
      pad_digital_en <= digital_enable_bits_r;
      periph_in <= sync2_r & digital_enable_bits_r;
      port_irq <= |masked_status;
      // One-cycle pulse on the rise of the unmasked trigger pin's status.
      trig_prev_r <= trig_now;
      conv_trigger <= trig_now & ~trig_prev_r;
    end
  end

endmodule

// [testbench/gpmp_monitor.sv]
`timescale 1ns/1ps
module gpmp_monitor #(
  parameter [7:0] PROTECT_MASK = 8'h00
) (
  // Clock and reset.
  input wire sys_clk,
  input wire rst_n,
  // Register port.
  input wire [11:0] reg_addr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  // Pads and events.
  input wire [7:0] pad_in,
  input wire [7:0] pad_oe_n,
  input wire [7:0] pad_pull_up,
  input wire [7:0] pad_pull_down,
  input wire [7:0] pad_drive_2ma,
  input wire [7:0] pad_digital_en,
  input wire [7:0] periph_in,
  input wire port_irq,
  input wire conv_trigger
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Read data stands for one cycle only, so every other cycle must read zero.
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside a read");
  a_value_mask: assert property (reg_rd && reg_addr[11:10] == 2'b00 |=>
    (reg_rdata[7:0] & ~$past(reg_addr[9:2])) == 8'h00)
    else $error("masked value bit read as one");
  a_upper_zero: assert property ($past(reg_rd) |-> reg_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_trig_pulse: assert property (conv_trigger |=> !conv_trigger)
    else $error("converter trigger longer than one cycle");
  a_trig_irq: assert property (conv_trigger |-> port_irq)
    else $error("converter trigger without port interrupt");
  // A pad may only be driven while its digital path is enabled.
  a_oe_den: assert property ((~pad_oe_n & ~pad_digital_en) == 8'h00)
    else $error("pad driven with digital enable off");
  a_reset_cfg: assert property ($rose(rst_n) |=> pad_pull_up == PROTECT_MASK
    && pad_digital_en == PROTECT_MASK && pad_pull_down == 8'h00 && pad_drive_2ma == 8'hFF)
    else $error("pad defaults wrong after reset");
  a_sync_in: assert property (($stable(pad_in) && $stable(pad_digital_en))[*4]
    |-> periph_in == (pad_in & pad_digital_en))
    else $error("peripheral input does not follow settled pad");
  c_trig: cover property (conv_trigger);
  c_irq: cover property ($rose(port_irq));
  c_value_rd: cover property (reg_rd && reg_addr[11:10] == 2'b00);
endmodule

bind gpmp_port gpmp_monitor #(.PROTECT_MASK(PROTECT_MASK)) mon_u (.*);

// [testbench/gpmp_pin_model.sv]
`timescale 1ns/1ps
module gpmp_pin_model (
  // Clock.
  input wire sys_clk,
  // Pad side of the port.
  input wire [7:0] pad_out,
  input wire [7:0] pad_oe_n,
  input wire [7:0] pad_pull_up,
  input wire [7:0] pad_pull_down,
  // Outside drivers commanded by the bench.
  input wire [7:0] ext_en,
  input wire [7:0] ext_val,
  output reg [7:0] pad_in
);
  integer i;
  initial pad_in = 8'h00;
  // A floating pin with no pull flips every cycle, so a stale level is never read.
  always @(posedge sys_clk) begin
    for (i = 0; i < 8; i = i + 1) begin
      if (!pad_oe_n[i]) begin
        pad_in[i] <= pad_out[i];
      end else if (ext_en[i]) begin
        pad_in[i] <= ext_val[i];
      end else if (pad_pull_up[i] || pad_pull_down[i]) begin
        pad_in[i] <= pad_pull_up[i];
      end else begin
        pad_in[i] <= ~pad_in[i];
      end
    end
  end
endmodule

// [testbench/gpmp_port_tb.sv]
`timescale 1ns/1ps
`include "gpmp_defs.vh"
module gpmp_port_tb;
  localparam [7:0] PROT = 8'h80;
  localparam [7:0] ID = 8'h3C; // Arbitrary identification value.
  reg sys_clk, rst_n, reg_wr, reg_rd;
  reg [11:0] reg_addr;
  reg [31:0] reg_wdata;
  reg [7:0] periph_out, periph_oe, ext_en, ext_val;
  wire [31:0] reg_rdata;
  wire [7:0] pad_in, pad_out, pad_oe_n, pu, pd, slew, den, periph_in, d2, d4, d8;
  wire port_irq, conv_trigger;
  integer n_fail, checks_done, trig_n, k;
  gpmp_port #(.PROTECT_MASK(PROT), .TRIG_MASK(8'h10), .ID_BYTE(ID)) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pull_up(pu), .pad_pull_down(pd),
    .pad_drive_2ma(d2), .pad_drive_4ma(d4), .pad_drive_8ma(d8), .pad_slew_limit(slew),
    .pad_digital_en(den), .periph_out(periph_out), .periph_oe(periph_oe),
    .periph_in(periph_in), .port_irq(port_irq), .conv_trigger(conv_trigger));
  gpmp_pin_model m_u (.sys_clk(sys_clk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pad_pull_up(pu), .pad_pull_down(pd), .ext_en(ext_en), .ext_val(ext_val),
    .pad_in(pad_in));
  // Free-running system clock.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Count converter trigger pulses as they go by.
  always @(posedge sys_clk) if (conv_trigger === 1'b1) trig_n <= trig_n + 1;
  task results;
    begin
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("ERROR %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task w(input [9:0] ix, input [31:0] d);
    begin
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= {ix, 2'b00};
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
    end
  endtask
  // Read data is looked at in the one cycle where it stands.
  task r(input [9:0] ix, input [31:0] e, input string nm);
    begin
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= {ix, 2'b00};
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk(nm, e, reg_rdata);
    end
  endtask
  // The outside source holds each level long enough to pass the synchroniser.
  task ext(input [7:0] v);
    begin
      @(posedge sys_clk);
      ext_val <= v;
      repeat (5) @(posedge sys_clk);
    end
  endtask
  task wait_irq(input v);
    begin
      k = 0;
      while (port_irq !== v && k < 20) begin
        @(posedge sys_clk);
        k = k + 1;
      end
      chk("port_irq", v, port_irq);
      if (port_irq !== v) results;
    end
  endtask
  task do_reset;
    begin
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
    end
  endtask
  task defaults;
    begin
      r(10'h108, PROT, "alt");
      r(10'h147, PROT, "den");
      r(10'h144, PROT, "pur");
      r(10'h145, 8'h00, "pdr");
      r(10'h149, {24'h000000, ~PROT}, "commit");
      r(10'h100, 8'h00, "dir");
      chk("oe_n", 8'hFF, pad_oe_n);
    end
  endtask
  // Main sequence: defaults, data path, commit, interrupts, pads, second reset.
  initial begin
    rst_n = 1'b0;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = 46'h0;
    {periph_out, periph_oe, ext_val} = 24'h0;
    ext_en = 8'hF0;
    {n_fail, checks_done, trig_n} = 96'h0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    defaults;
    w(10'h147, 8'hFF);
    w(10'h100, 8'h0F);
    w(10'h0FF, 8'h00);
    w(10'h026, 8'hEB);
    r(10'h07F, 8'h02, "value");
    r(10'h031, 8'h00, "value");
    chk("pad_out", 4'h2, pad_out[3:0]);
    chk("oe_n", 4'h0, pad_oe_n[3:0]);
    ext(8'h50);
    r(10'h07F, 8'h52, "value");
    r(10'h0F1, 8'h50, "value");
    chk("periph_in", 8'h52, periph_in);
    @(posedge sys_clk);
    periph_oe <= 8'h80;
    periph_out <= 8'h80;
    repeat (3) @(posedge sys_clk);
    chk("alt_drive", 2'b01, {pad_oe_n[7], pad_out[7]});
    periph_oe <= 8'h00;
    w(10'h108, 8'h01);
    r(10'h108, 8'h81, "alt");
    w(10'h149, 8'h80);
    r(10'h149, 8'h7F, "commit");
    w(10'h148, `GPMP_LOCK_KEY);
    r(10'h148, 32'h0, "lock");
    w(10'h149, 8'hFF);
    w(10'h108, 8'h00);
    r(10'h108, 8'h00, "alt");
    w(10'h148, 32'h0);
    r(10'h148, 32'h1, "lock");
    ext(8'h00);
    w(10'h104, 8'h00);
    w(10'h101, 8'h20);
    w(10'h102, 8'h40);
    w(10'h103, 8'h30);
    w(10'h107, 8'hFF);
    w(10'h104, 8'h10);
    r(10'h105, 8'h00, "raw");
    ext(8'h10);
    wait_irq(1'b1);
    r(10'h106, 8'h10, "mstat");
    ext(8'h00);
    w(10'h107, 8'h00);
    r(10'h105, 8'h10, "raw");
    chk("trig", 1, trig_n);
    w(10'h107, 8'h10);
    wait_irq(1'b0);
    w(10'h104, 8'h20);
    ext(8'h60);
    r(10'h105, 8'h60, "raw");
    r(10'h106, 8'h20, "mstat");
    wait_irq(1'b1);
    ext(8'h40);
    wait_irq(1'b0);
    w(10'h107, 8'h40);
    ext(8'h00);
    r(10'h105, 8'h40, "raw");
    w(10'h107, 8'h40);
    w(10'h104, 8'h00);
    w(10'h103, 8'h10);
    w(10'h105, 8'hFF);
    r(10'h105, 8'h20, "raw");
    chk("trig", 1, trig_n);
    for (k = 10'h140; k <= 10'h146; k = k + 1) begin
      w(k[9:0], 8'h3C);
      r(k[9:0], 8'h3C, "pad_ctl");
    end
    chk("pads", {8'h3C, 8'h3C}, {slew, pd});
    chk("drive_pu", 32'h3C3C3C3C, {d2, d4, d8, pu});
    r(10'h200, 32'h0, "unmapped");
    r(10'h3F4, ID, "ident");
    r(10'h3F5, ID ^ 8'h01, "ident");
    do_reset;
    defaults;
    results;
  end
endmodule
